// ===== rtl/dcit_interval_timer.sv
// Two-channel 16-bit interval timer with an APB register slave.
// Assumes APB requests synchronous to mclk, a standby level from the
// power controller and a module-stop level from the clock controller.
//
// Notes on behaviour
// - Two channels, each counter, constant, control.
// - Run register bit per channel starts counting.
// - Reserved bits read zero; software writes zero.
// - Run register cleared by reset and standby.
// - Bit 7 flag sets on counter match.
// - Flag writes only clear; one leaves it.
// - Interrupt request equals flag and enable.
// - Bits 1:0 pick divide 8/32/128/512.
// - Control register cleared by reset and standby.
// - Running counter increments once per tick.
// - Match clears counter and sets flag.
// - Counter cleared by reset and standby.
// - Constant set to all ones likewise.
// - Constant sets ticks between match events.
// - Tick rate chosen separately per channel.
// - Module-stop input freezes the whole timer.
// - Match acts on tick after equality.
// - Match clear beats a counter write.
// - Counter write beats increment; bytes kept.
// - Flag clear needs a prior read of one.
`timescale 1ns/1ns
`default_nettype none

module dcit_interval_timer (
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  input  wire logic                      standby,
  input  wire logic                      module_stop,
  input  wire dcit_pkg::dcit_apb_req_type apb_req,
  output      dcit_pkg::dcit_apb_rsp_type apb_rsp,
  output      logic [1:0]                match_irq
);
  import dcit_pkg::*;

  dcit_state_type s_r;
  dcit_state_type s_nxt;

  logic       acc;
  logic       setup_rd;
  logic       hit;
  logic       wr;
  logic [1:0] tick;
  logic [1:0] match_ev;
  logic [1:0] wr_csr;
  logic [1:0] wr_cnt;
  logic [1:0] wr_cor;
  logic [1:0] rd_csr;
  logic [15:0] cnt_wdata [0:1];
  logic [15:0] cor_wdata [0:1];

  // Selected tick for a channel: a one-cycle pulse derived from the
  // free-running prescaler, so everything stays on mclk.
  function automatic logic tick_of(input logic [1:0] cks,
                                   input logic [PRE_W-1:0] pre);
    logic t;
    t = 1'b1;
    for (int b = 0; b < PRE_W; b++) begin
      if (b < DIV_LOG2[cks] && !pre[b]) begin
        t = 1'b0;
      end
    end
    return t;
  endfunction

  // Bus decode. The slave answers with no wait states, so every access
  // phase completes at its first edge.
  assign acc      = apb_req.psel & apb_req.penable;
  assign setup_rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign hit      = (apb_req.paddr == OFS_RUN)
                  | (apb_req.paddr == OFS_CSR[0])
                  | (apb_req.paddr == OFS_CNT[0])
                  | (apb_req.paddr == OFS_COR[0])
                  | (apb_req.paddr == OFS_CSR[1])
                  | (apb_req.paddr == OFS_CNT[1])
                  | (apb_req.paddr == OFS_COR[1]);
  assign wr       = acc & apb_req.pwrite & hit;

  // Response: read data comes from a flop captured in the setup cycle.
  // One assignment drives the whole struct, so the output has one driver.
  assign apb_rsp = '{prdata:  s_r.prdata,
                     pready:  1'b1,
                     pslverr: acc & ~hit};

  // Per-channel strobes, ticks and the interrupt request.
  for (genvar i = 0; i < 2; i++) begin : g_chan
    // Module stop gates the tick, so a stopped timer sees no events.
    assign tick[i] = s_r.run[i] & ~module_stop & ~standby
                   & tick_of(s_r.ch[i].cks, s_r.pre);
    // Equality is acted on at the next tick, which also zeroes the count.
    assign match_ev[i] = tick[i]
                       & (s_r.ch[i].cnt == s_r.ch[i].cor);
    assign wr_csr[i] = wr & (apb_req.paddr == OFS_CSR[i]) & apb_req.pstrb[0];
    assign wr_cnt[i] = wr & (apb_req.paddr == OFS_CNT[i])
                     & (|apb_req.pstrb[1:0]);
    assign wr_cor[i] = wr & (apb_req.paddr == OFS_COR[i])
                     & (|apb_req.pstrb[1:0]);
    assign rd_csr[i] = setup_rd & (apb_req.paddr == OFS_CSR[i]);
    // Byte lanes that are not strobed keep their previous contents.
    assign cnt_wdata[i] = {apb_req.pstrb[1] ? apb_req.pwdata[15:8]
                                            : s_r.ch[i].cnt[15:8],
                           apb_req.pstrb[0] ? apb_req.pwdata[7:0]
                                            : s_r.ch[i].cnt[7:0]};
    assign cor_wdata[i] = {apb_req.pstrb[1] ? apb_req.pwdata[15:8]
                                            : s_r.ch[i].cor[15:8],
                           apb_req.pstrb[0] ? apb_req.pwdata[7:0]
                                            : s_r.ch[i].cor[7:0]};
    assign match_irq[i] = s_r.ch[i].flag & s_r.ch[i].ie;
  end

  // Next-state logic for the whole timer.
  always_comb begin
    s_nxt = s_r;
    if (standby) begin
      // Standby reinitialises every register; prescaler phase restarts.
      s_nxt = STATE_RST;
    end else if (!module_stop) begin
      s_nxt.pre = s_r.pre + {{(PRE_W-1){1'b0}}, 1'b1};

      if (wr && apb_req.paddr == OFS_RUN && apb_req.pstrb[0]) begin
        s_nxt.run = apb_req.pwdata[1:0];
      end

      for (int i = 0; i < 2; i++) begin
        // Counter: match clear, then software write, then increment.
        if (match_ev[i]) begin
          s_nxt.ch[i].cnt = CNT_RST;
        end else if (wr_cnt[i]) begin
          s_nxt.ch[i].cnt = cnt_wdata[i];
        end else if (tick[i]) begin
          s_nxt.ch[i].cnt = s_r.ch[i].cnt + 16'h0001;
        end

        if (wr_cor[i]) begin
          s_nxt.ch[i].cor = cor_wdata[i];
        end

        // A read that returns the flag as one arms the clear.
        if (rd_csr[i] && s_r.ch[i].flag) begin
          s_nxt.ch[i].seen = 1'b1;
        end

        if (wr_csr[i]) begin
          s_nxt.ch[i].ie  = apb_req.pwdata[CSR_IE_BIT];
          s_nxt.ch[i].cks = apb_req.pwdata[CSR_CKS_LSB+1:CSR_CKS_LSB];
          if (!apb_req.pwdata[CSR_FLAG_BIT] && s_r.ch[i].seen) begin
            s_nxt.ch[i].flag = 1'b0;
          end
          s_nxt.ch[i].seen = 1'b0;
        end

        // Set after clear: a match in the clearing cycle is not lost.
        if (match_ev[i]) begin
          s_nxt.ch[i].flag = 1'b1;
          s_nxt.ch[i].seen = 1'b0;
        end
      end

      // Read data; reserved bits stay zero.
      if (setup_rd) begin
        s_nxt.prdata = 32'h0000_0000;
        case (apb_req.paddr)
          OFS_RUN: begin
            s_nxt.prdata[1:0] = s_r.run;
          end
          OFS_CSR[0], OFS_CSR[1]: begin
            for (int i = 0; i < 2; i++) begin
              if (apb_req.paddr == OFS_CSR[i]) begin
                s_nxt.prdata[CSR_FLAG_BIT] = s_r.ch[i].flag;
                s_nxt.prdata[CSR_IE_BIT]   = s_r.ch[i].ie;
                s_nxt.prdata[CSR_CKS_LSB+1:CSR_CKS_LSB] = s_r.ch[i].cks;
              end
            end
          end
          OFS_CNT[0]: begin
            s_nxt.prdata[15:0] = s_r.ch[0].cnt;
          end
          OFS_CNT[1]: begin
            s_nxt.prdata[15:0] = s_r.ch[1].cnt;
          end
          OFS_COR[0]: begin
            s_nxt.prdata[15:0] = s_r.ch[0].cor;
          end
          OFS_COR[1]: begin
            s_nxt.prdata[15:0] = s_r.ch[1].cor;
          end
          default: begin
            s_nxt.prdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // State register. Module stop is realised as a hold of all state,
  // since a real clock gate belongs to the clock controller.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Checks of the timer behaviour.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  logic tick8;
  assign tick8 = ~module_stop & ~standby & (&s_r.pre[2:0]);

  chk_rsvd_zero : assert property (
    acc && !apb_req.pwrite && !$past(module_stop)
      |-> apb_rsp.prdata[31:16] == 16'h0000
      && (apb_req.paddr != OFS_CSR[0] || apb_rsp.prdata[5:2] == 4'h0))
    else $error("Reserved read bits are not zero.");

  chk_irq_gate : assert property (
    match_irq[1] == (s_r.ch[1].flag && s_r.ch[1].ie)
      && match_irq[0] == (s_r.ch[0].flag && s_r.ch[0].ie))
    else $error("Interrupt request disagrees with flag and enable.");

  chk_match_clear : assert property (
    match_ev[0] && !standby |=> s_r.ch[0].cnt == 16'h0000
      && s_r.ch[0].flag)
    else $error("Match did not clear counter and set flag.");

  chk_match_wins : assert property (
    match_ev[1] && wr_cnt[1] && !standby |=> s_r.ch[1].cnt == 16'h0000)
    else $error("Counter write beat a match clear.");

  chk_write_wins : assert property (
    wr_cnt[0] && !match_ev[0] && !standby && !module_stop
      |=> s_r.ch[0].cnt == $past(cnt_wdata[0]))
    else $error("Counter write lost to increment.");

  chk_count_step : assert property (
    tick[0] && !match_ev[0] && !wr_cnt[0] && !standby
      |=> s_r.ch[0].cnt == $past(s_r.ch[0].cnt) + 16'h0001)
    else $error("Counter did not step by one on a tick.");

  chk_stopped_hold : assert property (
    !s_r.run[1] && !wr_cnt[1] && !standby |=> $stable(s_r.ch[1].cnt))
    else $error("Stopped counter changed.");

  chk_standby_init : assert property (
    standby |=> s_r.run == 2'h0 && s_r.ch[0].cor == 16'hffff
      && s_r.ch[1].cnt == 16'h0000 && !s_r.ch[1].flag
      && s_r.ch[0].cks == 2'h0)
    else $error("Standby did not reinitialise the registers.");

  chk_clear_armed : assert property (
    wr_csr[0] && s_r.ch[0].flag && !s_r.ch[0].seen |=> s_r.ch[0].flag)
    else $error("Flag cleared without a prior read of one.");

  chk_write_one : assert property (
    wr_csr[1] && !s_r.ch[1].flag && !match_ev[1]
      && apb_req.pwdata[CSR_FLAG_BIT] |=> !s_r.ch[1].flag)
    else $error("Writing one set the flag.");

  chk_tick_div8 : assert property (
    tick8 |=> !tick8 [*7])
    else $error("Divide-by-8 tick spacing wrong.");

  chk_stop_freeze : assert property (
    module_stop && !standby |=> $stable(s_r.ch[0].cnt) && $stable(s_r.pre))
    else $error("Timer moved under module stop.");

  // Second channel mirrors of the counter and flag checks above.
  chk_match_clr1 : assert property (
    match_ev[1] && !standby |=> s_r.ch[1].cnt == 16'h0000
      && s_r.ch[1].flag)
    else $error("Channel 1 match did not clear counter and set flag.");

  // Only a match event may raise the flag; nothing else sets it.
  chk_no_false_set : assert property (
    !match_ev[0] && !s_r.ch[0].flag |=> !s_r.ch[0].flag)
    else $error("Flag set without a match event.");

  // Equality alone does nothing until the next tick arrives.
  chk_late_match : assert property (
    s_r.ch[1].cnt == s_r.ch[1].cor && !tick[1] && !wr_cnt[1] && !standby
      |=> s_r.ch[1].cnt == $past(s_r.ch[1].cnt))
    else $error("Counter moved on equality without a tick.");

  // An armed clear with a zero written to the flag must take effect.
  chk_flag_clear : assert property (
    wr_csr[0] && s_r.ch[0].seen && !apb_req.pwdata[CSR_FLAG_BIT]
      && !match_ev[0] && !module_stop && !standby |=> !s_r.ch[0].flag)
    else $error("Armed flag clear did not clear the flag.");

  // Any control write consumes the arm, so a stale read cannot clear.
  chk_seen_drop : assert property (
    wr_csr[1] && !module_stop && !standby |=> !s_r.ch[1].seen)
    else $error("Clear arm survived a control write.");

  chk_run_write : assert property (
    wr && apb_req.paddr == OFS_RUN && apb_req.pstrb[0] && !module_stop
      && !standby |=> s_r.run == $past(apb_req.pwdata[1:0]))
    else $error("Run register write did not land.");

  chk_cor_write : assert property (
    wr_cor[0] && (&apb_req.pstrb[1:0]) && !module_stop && !standby
      |=> s_r.ch[0].cor == $past(apb_req.pwdata[15:0]))
    else $error("Compare constant write did not land.");

  // A low-byte write must not disturb the high byte of the counter.
  chk_byte_keep : assert property (
    wr_cnt[1] && !apb_req.pstrb[1] && !match_ev[1] && !module_stop
      && !standby |=> s_r.ch[1].cnt[15:8] == $past(s_r.ch[1].cnt[15:8]))
    else $error("Unwritten counter byte changed.");

  // Tick phase against the prescaler for the slower ratios.
  chk_slow_tick : assert property (
    tick[0] && s_r.ch[0].cks == 2'h3 |-> (&s_r.pre))
    else $error("Divide-by-512 tick at the wrong phase.");

  chk_mid_tick : assert property (
    tick[1] && s_r.ch[1].cks == 2'h1 |-> s_r.pre[4:0] == 5'h1f)
    else $error("Divide-by-32 tick at the wrong phase.");

  // A tick is a single-cycle enable, never a level.
  chk_tick_once : assert property (
    tick[0] |=> !tick[0])
    else $error("Tick lasted more than one cycle.");

  // Writing one channel's control leaves the other's rate alone.
  chk_split_rate : assert property (
    wr_csr[0] && !module_stop && !standby
      |=> s_r.ch[1].cks == $past(s_r.ch[1].cks))
    else $error("Channel 0 write changed channel 1 rate.");

  chk_csr1_rsvd : assert property (
    acc && !apb_req.pwrite && apb_req.paddr == OFS_CSR[1]
      && !$past(module_stop)
      |-> apb_rsp.prdata[15:8] == 8'h00 && apb_rsp.prdata[5:2] == 4'h0)
    else $error("Channel 1 reserved read bits are not zero.");

  chk_standby_ch1 : assert property (
    standby |=> s_r.ch[1].cor == 16'hffff && s_r.ch[0].cnt == 16'h0000
      && !s_r.ch[0].ie && s_r.ch[1].cks == 2'h0)
    else $error("Standby did not reinitialise channel registers.");

  chk_stop_ch1 : assert property (
    module_stop && !standby |=> $stable(s_r.ch[1].cnt) && $stable(s_r.run)
      && $stable(s_r.ch[1].flag))
    else $error("Channel 1 moved under module stop.");

  chk_stopped_ch0 : assert property (
    !s_r.run[0] && !wr_cnt[0] && !standby |=> $stable(s_r.ch[0].cnt))
    else $error("Stopped channel 0 counter changed.");

  cov_match0 : cover property (match_ev[0] ##1 match_irq[0]);
  cov_match1 : cover property (match_ev[1] && s_r.ch[1].cks == 2'h3);
  cov_flag_clear : cover property (s_r.ch[0].flag ##1 !s_r.ch[0].flag);
  cov_bus_error : cover property (apb_rsp.pslverr);
  cov_both_run : cover property (tick[0] && tick[1]
                                 && s_r.ch[0].cks != s_r.ch[1].cks);

endmodule

`default_nettype wire

// ===== rtl/dcit_pkg.sv
// Package for the two-channel interval timer: register map, field
// positions, reset values, prescaler ratios and the carrier structs.
// Assumes an APB bus with 32-bit data and 5 address bits.
package dcit_pkg;

  // Byte addresses of the registers, one aligned word each.
  localparam logic [4:0] OFS_RUN = 5'h00;
  localparam logic [4:0] OFS_CSR [0:1] = '{5'h04, 5'h10};
  localparam logic [4:0] OFS_CNT [0:1] = '{5'h08, 5'h14};
  localparam logic [4:0] OFS_COR [0:1] = '{5'h0c, 5'h18};

  // Field positions inside the control/status register.
  localparam int CSR_FLAG_BIT = 7;
  localparam int CSR_IE_BIT   = 6;
  localparam int CSR_CKS_LSB  = 0;

  // Reset values.
  localparam logic [1:0]  RUN_RST = 2'h0;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] COR_RST = 16'hffff;
  localparam logic [1:0]  CKS_RST = 2'h0;

  // Prescaler: the tick for select n fires when the low DIV_LOG2[n]
  // bits of the free-running prescaler are all ones.
  localparam int PRE_W = 9;
  localparam int DIV_LOG2 [0:3] = '{3, 5, 7, 9};

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [4:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } dcit_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dcit_apb_rsp_type;

  typedef struct packed {
    logic        flag;
    logic        seen;
    logic        ie;
    logic [1:0]  cks;
    logic [15:0] cnt;
    logic [15:0] cor;
  } dcit_chan_type;

  localparam dcit_chan_type CHAN_RST = '{flag: 1'b0, seen: 1'b0, ie: 1'b0,
                                        cks: CKS_RST, cnt: CNT_RST,
                                        cor: COR_RST};

  typedef struct packed {
    logic [1:0]          run;
    logic [PRE_W-1:0]    pre;
    dcit_chan_type [1:0] ch;
    logic [31:0]         prdata;
  } dcit_state_type;

  localparam dcit_state_type STATE_RST = '{run: RUN_RST, pre: '0,
                                          ch: {CHAN_RST, CHAN_RST},
                                          prdata: 32'h0000_0000};

endpackage

// ===== test/tb_top.sv
// Self-checking bench for the two-channel interval timer.
// Assumes the design package and the timer module are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import dcit_pkg::*;

  logic             mclk;
  logic             rst_b;
  logic             standby;
  logic             module_stop;
  dcit_apb_req_type apb_req;
  dcit_apb_rsp_type apb_rsp;
  logic [1:0]       match_irq;
  logic [32:0]      exp_q[$];
  logic [31:0]      seed = 32'h0000_0019;
  int               err_total = 0;
  int               cmp_count = 0;
  int               cyc = 0;

  dcit_interval_timer dcit_interval_timer_i (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .standby     (standby),
    .module_stop (module_stop),
    .apb_req     (apb_req),
    .apb_rsp     (apb_rsp),
    .match_irq   (match_irq)
  );

  // Free clock and a cycle stamp used to time match intervals.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic summarize();
    $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic bad(input string msg);
    err_total++;
    $display("BAD %0t %s", $time, msg);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) bad($sformatf("got %h want %h", got, want));
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                 pwdata: d, pstrb: s};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad("bus answer timeout");
      summarize();
    end
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    apb(1'b1, a, d, s);
  endtask

  // A read leaves its expected slave-error and data in the queue.
  task automatic rd(input logic [4:0] a, input logic [31:0] d,
                    input logic err = 1'b0);
    exp_q.push_back({err, d});
    apb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask

  // Bounded wait for one channel's request to reach a level.
  task automatic wait_lvl(input int ch, input logic v);
    int n;
    n = 0;
    while (match_irq[ch] !== v && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) begin
      bad("interrupt level timeout");
      summarize();
    end
  endtask

  task automatic chk_rst();
    rd(OFS_RUN, 32'h0000_0000);
    for (int ch = 0; ch < 2; ch++) begin
      rd(OFS_CSR[ch], 32'h0000_0000);
      rd(OFS_CNT[ch], 32'h0000_0000);
      rd(OFS_COR[ch], 32'h0000_ffff);
    end
  endtask

  // Read data is compared when the access phase completes.
  always @(posedge mclk) begin
    if (apb_req.psel && apb_req.penable && !apb_req.pwrite &&
        apb_rsp.pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad("read without expectation");
      end else begin
        cmp_count++;
        if ({apb_rsp.pslverr, apb_rsp.prdata} !== exp_q[0]) begin
          bad($sformatf("read %h want %h", apb_rsp.prdata, exp_q[0]));
        end
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    int t1;
    int t2;
    apb_req = '0;
    standby = 1'b0;
    module_stop = 1'b0;
    rst_b = 1'b0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    chk_rst();
    wr(OFS_RUN, 32'hffff_fffc);
    rd(OFS_RUN, 32'h0000_0000);
    wr(OFS_CSR[0], 32'hffff_ffbc);
    rd(OFS_CSR[0], 32'h0000_0000);
    rd(5'h1c, 32'h0000_0000, 1'b1);
    // Every tick rate on both channels; interval is four ticks.
    for (int ch = 0; ch < 2; ch++) begin
      for (int sel = 0; sel < 4; sel++) begin
        wr(OFS_RUN, 32'h0000_0000);
        wr(OFS_CNT[ch], 32'h0000_0000);
        wr(OFS_COR[ch], 32'h0000_0003);
        wr(OFS_CSR[ch], 32'h40 | sel);
        wr(OFS_RUN, 32'h1 << ch);
        wait_lvl(ch, 1'b1);
        t1 = cyc;
        chk(32'(match_irq[1 - ch]), 32'h0);
        wr(OFS_CSR[ch], 32'h40 | sel);
        // Let the write's edge settle before looking at the request.
        @(posedge mclk);
        chk(32'(match_irq[ch]), 32'h1);
        rd(OFS_CSR[ch], 32'hc0 | sel);
        wr(OFS_CSR[ch], 32'h40 | sel);
        wait_lvl(ch, 1'b0);
        wait_lvl(ch, 1'b1);
        t2 = cyc;
        chk(32'(t2 - t1), 32'(4 << (3 + 2 * sel)));
        rd(OFS_CSR[ch], 32'hc0 | sel);
        wr(OFS_CSR[ch], 32'h0000_0000);
        wait_lvl(ch, 1'b0);
      end
    end
    // Stopped counter keeps a random value; byte lanes stay apart.
    wr(OFS_RUN, 32'h0000_0000);
    seed = xs(seed);
    wr(OFS_CNT[0], {16'h0000, seed[15:0]});
    wr(OFS_CNT[0], {16'h0000, ~seed[15:0]}, 4'h1);
    rd(OFS_CNT[0], {16'h0000, seed[15:8], ~seed[7:0]});
    repeat (600) @(posedge mclk);
    rd(OFS_CNT[0], {16'h0000, seed[15:8], ~seed[7:0]});
    wr(OFS_COR[1], {16'h0000, seed[31:16]});
    rd(OFS_COR[1], {16'h0000, seed[31:16]});
    // Standby re-initialises everything that was configured.
    wr(OFS_CSR[0], 32'h0000_0041);
    wr(OFS_RUN, 32'h0000_0003);
    @(posedge mclk);
    standby <= 1'b1;
    repeat (2) @(posedge mclk);
    standby <= 1'b0;
    chk_rst();
    @(posedge mclk);
    module_stop <= 1'b1;
    wr(OFS_COR[1], 32'h0000_1234);
    module_stop <= 1'b0;
    rd(OFS_COR[1], 32'h0000_ffff);
    repeat (3) @(posedge mclk);
    summarize();
  end
endmodule

`default_nettype wire
